// ---- core/pu_port.sv ----
// Port control block: Wishbone registers, pin ownership and pad control
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
module pu_port #(
  parameter int unsigned NPINS = pu_pkg::PU_NPINS
) (
  input wire logic clk_i, // Bus clock, 25 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic ce_i, // Clock enable, freezes state when low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire pu_pkg::pu_periph_t periph_i, // Timer, PWM and analog requests
  input wire logic [7:0] port_pins_i, // Pin levels from pads
  output logic [7:0] port_pins_o, // Pin output values
  output logic [7:0] port_pins_oe_o, // Pin output enables, high drives
  output logic [7:0] port_pins_in_o, // Digital input seen by peripherals
  output pu_pkg::pu_pad_t pad_o // Pad control bundle
);
  typedef struct packed {
    pu_pkg::pu_cfg_t cfg;
    logic ack;
    logic [31:0] rdata;
  } pu_st_t;

  pu_st_t st_r;
  pu_st_t st_nxt;
  logic [7:0] pin_sync;
  logic [7:0] pin_level;
  logic [7:0] pwm_own;
  logic [7:0] tim_own;
  logic [7:0] per_out;
  logic [7:0] is_out;
  logic [7:0] gpio_out;
  logic [7:0] drv_val;
  logic [7:0] drv_en;
  logic [7:0] rd_byte;
  logic wr_stb;
  logic rd_stb;
  logic lane_ok;
  logic [7:0] wbyte;
  logic [7:0] pwm_en_w;
  logic [7:0] pwm_out_w;
  logic [7:0] tim_oc_w;
  logic [7:0] tim_out_w;

  initial begin
    if (NPINS != pu_pkg::PU_NPINS) begin
      $error("pu_port supports exactly eight pins");
    end
  end

  // Pin levels are asynchronous, so they are synchronized first
  pu_sync #(
    .WIDTH(8)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(port_pins_i),
    .q_o(pin_sync)
  );

  // Analog use forces digital reads high
  assign pin_level = pin_sync | periph_i.analog_en;

  // Widen channel vectors so every pin index stays in range
  assign pwm_en_w = {2'h0, periph_i.pwm_en};
  assign pwm_out_w = {2'h0, periph_i.pwm_out};
  assign tim_oc_w = {4'h0, periph_i.tim_oc};
  assign tim_out_w = {4'h0, periph_i.tim_out};

  // Ownership; routing only matters where both units want the pin
  always_comb begin
    pwm_own = 8'h00;
    tim_own = 8'h00;
    per_out = 8'h00;
    for (int i = 0; i < 8; i++) begin
      logic pwm_req;
      logic tim_req;
      pwm_req = 1'b0;
      tim_req = 1'b0;
      if (pu_pkg::PU_PWM_MASK[i]) begin
        pwm_req = pwm_en_w[i];
      end
      if (pu_pkg::PU_TIM_MASK[i]) begin
        // Capture channels leave tim_oc low and keep direction control
        tim_req = periph_i.tim_en & tim_oc_w[i];
      end
      if (pwm_req && tim_req) begin
        pwm_own[i] = st_r.cfg.route[i];
        tim_own[i] = ~st_r.cfg.route[i];
      end else begin
        pwm_own[i] = pwm_req;
        tim_own[i] = tim_req;
      end
      if (pwm_own[i]) begin
        per_out[i] = pwm_out_w[i];
      end else if (tim_own[i]) begin
        per_out[i] = tim_out_w[i];
      end
    end
  end

  // Direction: peripheral ownership overrides the direction bit
  assign gpio_out = st_r.cfg.dir & ~(pwm_own | tim_own);
  assign is_out = st_r.cfg.dir | pwm_own | tim_own;
  assign drv_en = is_out & ~periph_i.analog_en;
  assign drv_val = (gpio_out & st_r.cfg.data) | ((pwm_own | tim_own) & per_out);

  // Pad controls; settings only act where the pin's use allows
  assign port_pins_o = drv_val & drv_en;
  assign port_pins_oe_o = drv_en;
  assign port_pins_in_o = pin_level;
  assign pad_o.out = drv_val & drv_en;
  assign pad_o.oe = drv_en;
  assign pad_o.reduced = st_r.cfg.drive & drv_en;
  assign pad_o.pull_on = st_r.cfg.pullen & ~is_out;
  assign pad_o.pull_down = st_r.cfg.pullsel & st_r.cfg.pullen & ~is_out;

  // Bus decode; byte lane 0 carries the register
  assign lane_ok = wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];
  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~st_r.ack & lane_ok;
  assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_we_i & ~st_r.ack;

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_byte = 8'h00;
    if (wb_adr_i == pu_pkg::PU_OFS_DATA) begin
      // Direction bit alone picks stored bit or pin
      rd_byte = (st_r.cfg.dir & st_r.cfg.data) | (~st_r.cfg.dir & pin_level);
    end else if (wb_adr_i == pu_pkg::PU_OFS_INPUT) begin
      rd_byte = pin_level;
    end else if (wb_adr_i == pu_pkg::PU_OFS_DIR) begin
      rd_byte = st_r.cfg.dir;
    end else if (wb_adr_i == pu_pkg::PU_OFS_DRIVE) begin
      rd_byte = st_r.cfg.drive;
    end else if (wb_adr_i == pu_pkg::PU_OFS_PULLEN) begin
      rd_byte = st_r.cfg.pullen;
    end else if (wb_adr_i == pu_pkg::PU_OFS_PULLSEL) begin
      rd_byte = st_r.cfg.pullsel;
    end else if (wb_adr_i == pu_pkg::PU_OFS_ROUTE) begin
      rd_byte = st_r.cfg.route & pu_pkg::PU_ROUTE_MASK;
    end
  end

  // Next state: registers, one-cycle ack, registered read data
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = wb_cyc_i & wb_stb_i & ~st_r.ack;
    if (rd_stb) begin
      st_nxt.rdata = {24'h00_0000, rd_byte};
    end
    if (wr_stb) begin
      // A write to a configuration register is stored whatever the pin currently does
      if (wb_adr_i == pu_pkg::PU_OFS_DATA) begin
        st_nxt.cfg.data = wbyte;
      end else if (wb_adr_i == pu_pkg::PU_OFS_DIR) begin
        st_nxt.cfg.dir = wbyte;
      end else if (wb_adr_i == pu_pkg::PU_OFS_DRIVE) begin
        st_nxt.cfg.drive = wbyte;
      end else if (wb_adr_i == pu_pkg::PU_OFS_PULLEN) begin
        st_nxt.cfg.pullen = wbyte;
      end else if (wb_adr_i == pu_pkg::PU_OFS_PULLSEL) begin
        st_nxt.cfg.pullsel = wbyte;
      end else if (wb_adr_i == pu_pkg::PU_OFS_ROUTE) begin
        st_nxt.cfg.route = wbyte & pu_pkg::PU_ROUTE_MASK;
      end
      // Input level register ignores writes
    end
  end

  // All configuration clears to inputs, no pulls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r.cfg.data <= pu_pkg::PU_RST_REG;
      st_r.cfg.dir <= pu_pkg::PU_RST_REG;
      st_r.cfg.drive <= pu_pkg::PU_RST_REG;
      st_r.cfg.pullen <= pu_pkg::PU_RST_REG;
      st_r.cfg.pullsel <= pu_pkg::PU_RST_REG;
      st_r.cfg.route <= pu_pkg::PU_RST_REG;
      st_r.ack <= 1'b0;
      st_r.rdata <= pu_pkg::PU_RD_ZERO;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdata;

  // Peripheral-owned pins always drive, unless analog
  a_pwm_force_out: assert property (@(posedge clk_i) disable iff (rst_i)
    (periph_i.pwm_en[0] && !periph_i.tim_en && !periph_i.analog_en[0]) |-> port_pins_oe_o[0])
    else $error("enabled PWM channel did not force output");
  a_tim_force_out: assert property (@(posedge clk_i) disable iff (rst_i)
    (periph_i.tim_en && periph_i.tim_oc[3] && !periph_i.pwm_en[3] && !periph_i.analog_en[3])
      |-> port_pins_oe_o[3])
    else $error("timer compare did not force output");
  a_route_pick: assert property (@(posedge clk_i) disable iff (rst_i)
    (periph_i.pwm_en[1] && periph_i.tim_en && periph_i.tim_oc[1] && !periph_i.analog_en[1])
      |-> port_pins_o[1] == (st_r.cfg.route[1] ? periph_i.pwm_out[1] : periph_i.tim_out[1]))
    else $error("routing bit chose wrong owner");
  a_analog_off: assert property (@(posedge clk_i) disable iff (rst_i)
    periph_i.analog_en[2] |-> (!port_pins_oe_o[2] && port_pins_in_o[2]))
    else $error("analog pin still digital");
  a_pull_inputs: assert property (@(posedge clk_i) disable iff (rst_i)
    (pad_o.pull_on & is_out) == 8'h00)
    else $error("pull active on output pin");
  a_reduced_in: assert property (@(posedge clk_i) disable iff (rst_i)
    (pad_o.reduced & ~drv_en) == 8'h00)
    else $error("reduced drive on input pin");
  a_route_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.cfg.route & ~pu_pkg::PU_ROUTE_MASK) == 8'h00)
    else $error("routing upper bits set");
  a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && ce_i) |=> !wb_ack_o)
    else $error("ack held two cycles");

  a_reset_inputs: assert property (@(posedge clk_i)
    rst_i |=> (st_r.cfg.dir == 8'h00 && st_r.cfg.pullen == 8'h00))
    else $error("pins not inputs after reset");

  a_gpio_data: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.cfg.dir[7] && !periph_i.analog_en[7]) |-> port_pins_o[7] == st_r.cfg.data[7])
    else $error("stored data not on GPIO output");

  // Pad bundle and loose pins must tell the same story
  a_oe_pad: assert property (@(posedge clk_i) disable iff (rst_i)
    pad_o.oe == port_pins_oe_o)
    else $error("pad enable differs from pin enable");

  a_out_pad: assert property (@(posedge clk_i) disable iff (rst_i)
    pad_o.out == port_pins_o)
    else $error("pad value differs from pin value");

  // Undriven pins show zero so nothing leaks through a disabled driver
  a_out_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    (port_pins_o & ~port_pins_oe_o) == 8'h00)
    else $error("value on undriven pin");

  // Analog use wins over every digital owner
  a_analog_all: assert property (@(posedge clk_i) disable iff (rst_i)
    (port_pins_oe_o & periph_i.analog_en) == 8'h00)
    else $error("analog pin driven");

  a_analog_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (port_pins_in_o & periph_i.analog_en) == periph_i.analog_en)
    else $error("analog pin not reading one");

  // Input view is the second synchronizer stage, forced high on analog pins
  a_in_sync: assert property (@(posedge clk_i) disable iff (rst_i)
    port_pins_in_o == (pin_sync | periph_i.analog_en))
    else $error("input view bypasses synchronizer");

  // Any owned pin drives unless analog
  a_owned_out: assert property (@(posedge clk_i) disable iff (rst_i)
    ((pwm_own | tim_own) & ~periph_i.analog_en & ~port_pins_oe_o) == 8'h00)
    else $error("owned pin not driving");

  // Pins 7:6 carry no PWM or timer channel, pins 5:4 no timer
  a_upper_gpio: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwm_own[7:6] == 2'h0) && (tim_own[7:4] == 4'h0))
    else $error("peripheral owns a GPIO-only pin");

  a_upper_dir: assert property (@(posedge clk_i) disable iff (rst_i)
    port_pins_oe_o[7:6] == (st_r.cfg.dir[7:6] & ~periph_i.analog_en[7:6]))
    else $error("upper pin direction wrong");

  // A set direction bit always drives unless analog
  a_gpio_dir: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.cfg.dir & ~periph_i.analog_en & ~port_pins_oe_o) == 8'h00)
    else $error("output pin not driving");

  // Capture channel leaves the direction bit in charge
  a_capture_dir: assert property (@(posedge clk_i) disable iff (rst_i)
    (periph_i.tim_en && !periph_i.tim_oc[0] && !periph_i.pwm_en[0]
      && !periph_i.analog_en[0]) |-> port_pins_oe_o[0] == st_r.cfg.dir[0])
    else $error("capture pin direction overridden");

  // Disabled channels hand the pin back to the direction bit
  a_pwm_off_dir: assert property (@(posedge clk_i) disable iff (rst_i)
    (!periph_i.pwm_en[4] && !periph_i.analog_en[4])
      |-> port_pins_oe_o[4] == st_r.cfg.dir[4])
    else $error("direction not restored after PWM");

  a_tim_off_dir: assert property (@(posedge clk_i) disable iff (rst_i)
    (!periph_i.tim_en && !periph_i.pwm_en[3] && !periph_i.analog_en[3])
      |-> port_pins_oe_o[3] == st_r.cfg.dir[3])
    else $error("direction not restored after timer");

  // Routing bit low hands a shared pin to the timer
  a_route_tim: assert property (@(posedge clk_i) disable iff (rst_i)
    (periph_i.pwm_en[2] && periph_i.tim_en && periph_i.tim_oc[2]
      && !st_r.cfg.route[2] && !periph_i.analog_en[2])
      |-> port_pins_o[2] == periph_i.tim_out[2])
    else $error("timer lost shared pin");

  // Pull direction only where a pull is on
  a_pull_down_only: assert property (@(posedge clk_i) disable iff (rst_i)
    (pad_o.pull_down & ~pad_o.pull_on) == 8'h00)
    else $error("pull-down without pull enable");

  a_pull_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    pad_o.pull_down == (pad_o.pull_on & st_r.cfg.pullsel))
    else $error("pull polarity wrong");

  a_pull_idle_out: assert property (@(posedge clk_i) disable iff (rst_i)
    (pad_o.pull_on & port_pins_oe_o) == 8'h00)
    else $error("pull on a driving pin");

  // Reduced drive follows the stored bit on every driving pin
  a_reduced_out: assert property (@(posedge clk_i) disable iff (rst_i)
    pad_o.reduced == (st_r.cfg.drive & port_pins_oe_o))
    else $error("reduced drive not applied");

  // Every request is answered one cycle later
  a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acknowledged");

  a_read_hi_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_dat_o[31:8] == 24'h00_0000)
    else $error("read data upper bits set");

  // Writes land whatever the pin does, input register ignores them
  a_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_stb && wb_adr_i == pu_pkg::PU_OFS_DIR)
      |=> st_r.cfg.dir == $past(wb_dat_i[7:0]))
    else $error("direction write lost");

  a_input_ro: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_stb && wb_adr_i == pu_pkg::PU_OFS_INPUT) |=> $stable(st_r.cfg))
    else $error("input register write changed state");

  // Output pins read back the stored bit
  a_data_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && rd_stb && wb_adr_i == pu_pkg::PU_OFS_DATA)
      |=> (wb_dat_o[7:0] & $past(st_r.cfg.dir)) == ($past(st_r.cfg.data) & $past(st_r.cfg.dir)))
    else $error("output pin read not stored bit");

  // Low clock enable freezes every register
  a_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(st_r))
    else $error("state moved while frozen");
endmodule // pu_port

// ---- core/pu_pkg.sv ----
// Package: register map, reset values and carrier structs for the port control block
// Contract
// - Output pins read stored data bit
// - Input pins read synchronized pin level
// - Input level register read only, always pins
// - Direction bit selects input or output
// - Enabled PWM channel forces pin output
// - PWM on bits 5:0, timer on 3:0
// - Timer compare channel forces pin output
// - Timer capture channel leaves direction bit
// - Routing bit picks timer or PWM
// - Reduced drive bit applies to outputs only
// - Pull enable applies to inputs only
// - Pull select: zero up, one down
// - Configuration writes accepted at any time
// - Data reaches pin only as GPIO output
// - Reads lag direction change two cycles
// - Analog enable kills driver, input reads one
// - Reset leaves all pins high-impedance inputs
package pu_pkg;
  localparam int unsigned PU_NPINS = 8;
  localparam int unsigned PU_ADDR_W = 8;
  localparam logic [7:0] PU_OFS_DATA = 8'h28;
  localparam logic [7:0] PU_OFS_INPUT = 8'h29;
  localparam logic [7:0] PU_OFS_DIR = 8'h2a;
  localparam logic [7:0] PU_OFS_DRIVE = 8'h2b;
  localparam logic [7:0] PU_OFS_PULLEN = 8'h2c;
  localparam logic [7:0] PU_OFS_PULLSEL = 8'h2d;
  localparam logic [7:0] PU_OFS_ROUTE = 8'h2e;
  localparam logic [7:0] PU_RST_REG = 8'h00;
  localparam logic [7:0] PU_ROUTE_MASK = 8'h0f;
  localparam logic [7:0] PU_PWM_MASK = 8'h3f;
  localparam logic [7:0] PU_TIM_MASK = 8'h0f;
  localparam logic [7:0] PU_ALL_ONES = 8'hff;
  localparam logic [31:0] PU_RD_ZERO = 32'h0000_0000;

  // Stored configuration, one byte per register
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] dir;
    logic [7:0] drive;
    logic [7:0] pullen;
    logic [7:0] pullsel;
    logic [7:0] route;
  } pu_cfg_t;

  // Peripheral requests towards the pins
  typedef struct packed {
    logic [5:0] pwm_en;
    logic [5:0] pwm_out;
    logic tim_en;
    logic [3:0] tim_oc;
    logic [3:0] tim_out;
    logic [7:0] analog_en;
  } pu_periph_t;

  // Pad controls per pin
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] reduced;
    logic [7:0] pull_on;
    logic [7:0] pull_down;
  } pu_pad_t;
endpackage

// ---- core/pu_sync.sv ----
// Two-stage synchronizer for a vector of pin levels
`timescale 1ns/1ps
module pu_sync #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clk_i, // Bus clock
  input wire logic rst_i, // Synchronous reset
  input wire logic ce_i, // Clock enable
  input wire logic [WIDTH-1:0] d_i, // Asynchronous levels
  output logic [WIDTH-1:0] q_o // Synchronized levels
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } pu_sync_st_t;

  pu_sync_st_t st_r;
  pu_sync_st_t st_nxt;

  initial begin
    if (WIDTH < 1) begin
      $error("pu_sync width must be at least one");
    end
  end

  // First stage feeds only the second one
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.s2;
endmodule // pu_sync

// ---- tb/pu_pin_model.sv ----
// Board-side pin model: resolves port drive, board source and pull devices
`timescale 1ns/1ps
module pu_pin_model (
  input wire logic clk_i, // Bus clock
  input wire pu_pkg::pu_pad_t pad_i, // Pad controls from the port
  input wire logic [7:0] ext_en_i, // Board source enables
  input wire logic [7:0] ext_val_i, // Board source levels
  output logic [7:0] pins_o // Resolved pin levels
);
  logic [7:0] float_r = 8'h00;
  // Undriven pins toggle, so a stale level never passes for a drive
  always @(posedge clk_i) begin
    float_r <= ~float_r;
  end
  // Port drive wins, then the board source, then the pull device
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_i.oe[i]) pins_o[i] = pad_i.out[i];
      else if (ext_en_i[i]) pins_o[i] = ext_val_i[i];
      else if (pad_i.pull_on[i]) pins_o[i] = ~pad_i.pull_down[i];
      else pins_o[i] = float_r[i];
    end
  end
endmodule // pu_pin_model

// ---- tb/testbench.sv ----
// Self-checking testbench for the port control block
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  pu_pkg::pu_periph_t per = '0;
  pu_pkg::pu_pad_t pad;
  logic [7:0] pins, pout, poe, pin_in;
  logic [7:0] ext_en = 8'hff;
  logic [7:0] ext_val = 8'h3c;
  logic ce = 1'b1;
  int mismatches = 0;
  int n_tests = 0;
  // Clock at 25 MHz
  always #20 clk_i = ~clk_i;
  pu_port i_pu_port (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .periph_i(per), .port_pins_i(pins),
    .port_pins_o(pout), .port_pins_oe_o(poe), .port_pins_in_o(pin_in), .pad_o(pad));
  pu_pin_model i_pu_pin_model (.clk_i(clk_i), .pad_i(pad), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pins_o(pins));
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Classic single cycle; waits for ack, which is also the data strobe
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= {24'h0, d};
    // Only the watchdog ends a wait that never sees ack
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, {24'h0, exp});
  endtask
  // Let synchronizer and combinational pad logic settle
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic t_reset();
    step(1);
    chk(poe, 8'h00);
    chk(pad.pull_on, 8'h00);
    for (int a = 8'h2a; a <= 8'h2e; a++) rd(8'(a), 8'h00);
    rd(8'h28, 8'h3c);
    $display("test reset done");
  endtask
  task automatic t_gpio();
    wr(8'h2a, 8'hf0);
    wr(8'h28, 8'ha5);
    step(4);
    chk(poe, 8'hf0);
    chk(pout, 8'ha0);
    chk(pad.out, 8'ha0);
    rd(8'h28, 8'hac);
    wr(8'h29, 8'hff);
    rd(8'h29, 8'hac);
    rd(8'h30, 8'h00);
    $display("test gpio done");
  endtask
  task automatic t_periph();
    wr(8'h2a, 8'h00);
    wr(8'h2e, 8'hf1);
    rd(8'h2e, 8'h01);
    per.pwm_en <= 6'h23;
    per.pwm_out <= 6'h3f;
    per.tim_en <= 1'b1;
    per.tim_oc <= 4'h6;
    per.tim_out <= 4'h0;
    step(2);
    chk(poe, 8'h27);
    chk(pout, 8'h21);
    wr(8'h2e, 8'h03);
    wr(8'h2a, 8'h08);
    step(1);
    chk(poe, 8'h2f);
    chk(pout, 8'h23);
    @(posedge clk_i);
    per.pwm_en <= 6'h00;
    per.tim_oc <= 4'h0;
    step(2);
    chk(poe, 8'h08);
    $display("test peripherals done");
  endtask
  task automatic t_pull();
    @(posedge clk_i);
    ext_en <= 8'h00;
    wr(8'h2a, 8'h0f);
    wr(8'h2b, 8'hff);
    wr(8'h2c, 8'hff);
    wr(8'h2d, 8'h55);
    step(4);
    chk(pad.pull_on, 8'hf0);
    chk(pad.pull_down, 8'h50);
    chk(pad.reduced, 8'h0f);
    rd(8'h29, 8'ha5);
    $display("test pulls done");
  endtask
  task automatic t_analog();
    @(posedge clk_i);
    per.analog_en <= 8'h81;
    step(4);
    chk(poe, 8'h0e);
    chk(pin_in & 8'h81, 8'h81);
    @(posedge clk_i);
    per.analog_en <= 8'h00;
    step(4);
    chk(poe, 8'h0f);
    $display("test analog done");
  endtask
  // Clock enable low must hold the synchronizer still
  task automatic t_freeze();
    @(posedge clk_i);
    ce <= 1'b0;
    ext_en <= 8'hff;
    ext_val <= 8'hc3;
    step(4);
    chk(pin_in, 8'ha5);
    @(posedge clk_i);
    ce <= 1'b1;
    step(3);
    chk(pin_in, 8'hc5);
    $display("test freeze done");
  endtask
  // Watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_gpio();
    t_periph();
    t_pull();
    t_analog();
    t_freeze();
    end_of_test();
  end
endmodule // testbench
